// [hw/pmicpc_code_decode.sv]
// Decoder from register codes to engineering values of the protection settings
`timescale 1ns/1ps
module pmicpc_code_decode
  import pmicpc_pkg::*;
(
  input  wire logic [3:0]  uv_code,        // Input undervoltage percent code
  input  wire logic [3:0]  ov_code,        // Input overvoltage percent code
  input  wire logic [3:0]  fuse_code,      // Fuse current limit code
  input  wire logic [1:0]  iss_code,       // Soft-start current code
  input  wire logic [7:0]  boost_code,     // Storage voltage code
  input  wire logic [6:0]  bus_code,       // Bus voltage code
  input  wire logic [2:0]  hsilim_code,    // High-side current limit code
  input  wire logic [1:0]  bus_uv_code,    // Bus undervoltage code
  output logic      [6:0]  uv_pct,         // Undervoltage percent
  output logic      [6:0]  ov_pct,         // Overvoltage percent, 0 when off
  output logic      [13:0] fuse_ma,        // Fuse limit in mA
  output logic      [8:0]  iss_ma,         // Soft-start limit in mA
  output logic      [15:0] boost_mv,       // Storage target in mV
  output logic      [15:0] bus_mv,         // Bus target in mV
  output logic      [3:0]  hsilim_a,       // High-side limit in A
  output logic      [6:0]  bus_uv_pct,     // Bus undervoltage percent
  output logic             bus_uv_rsvd     // Reserved bus undervoltage code
);

  // Percent thresholds
  assign uv_pct = 7'd80 + {3'h0, uv_code};
  assign ov_pct = (ov_code == 4'h0) ? 7'd0 : 7'd105 + {3'h0, ov_code};

  // Fuse limit: 1.5A, then 1A steps from 2A, saturating at 12A
  wire [3:0] fuse_clip = (fuse_code > 4'hb) ? 4'hb : fuse_code;
  assign fuse_ma = (fuse_code == 4'h0) ? 14'd1500 : 14'd1000 * {10'h0, fuse_clip} + 14'd1000;

  // Soft-start current table
  assign iss_ma = (iss_code == 2'h0) ? 9'd147 :
                  (iss_code == 2'h1) ? 9'd212 :
                  (iss_code == 2'h2) ? 9'd305 : 9'd483;

  // Regulator targets in 100mV steps
  assign boost_mv = 16'd5500 + 16'd100 * {8'h0, boost_code};
  assign bus_mv   = 16'd2500 + 16'd100 * {9'h0, bus_code};

  // Supplement buck limits
  assign hsilim_a    = 4'd3 + {1'b0, hsilim_code};
  assign bus_uv_pct  = bus_uv_code[0] ? 7'd70 : 7'd60;
  assign bus_uv_rsvd = bus_uv_code[1];

endmodule

// [hw/pmicpc_regs.sv]
// Protection configuration register bank with derived controls and FET retry logic
`timescale 1ns/1ps
module pmicpc_regs
  import pmicpc_pkg::*;
#(
  parameter logic [7:0]  OFS_TRIM_VAL  = 8'h80,             // Factory offset trim
  parameter logic [5:0]  GAIN_TRIM_VAL = 6'h20,             // Factory gain trim
  parameter logic [39:0] HCHK_CYCLES   = 40'(HCHK_BASE_CYCLES), // Base health check interval
  parameter logic [23:0] HICCUP_CYCLES = 24'(FET_HICCUP_CYCLES) // Blocking FET hiccup wait
)(
  input  wire logic        mclk,                // System clock
  input  wire logic        rst_b,               // Asynchronous reset, active low
  input  wire logic        reg_wr,              // Register write strobe
  input  wire logic        reg_rd,              // Register read strobe
  input  wire logic [7:0]  reg_addr,            // Register address
  input  wire logic [7:0]  reg_wdata,           // Register write data
  output logic      [7:0]  reg_rdata,           // Register read data
  output logic             reg_rvalid,          // Read data valid pulse
  output logic             reg_err,             // Unmapped access pulse
  input  wire logic [11:0] factory_nominal_input_uv, // Factory nominal input in mV
  output logic      [15:0] uv_threshold_mv,     // Input undervoltage threshold
  output logic      [15:0] ov_threshold_mv,     // Input overvoltage threshold
  output logic             ov_detect_en,        // Overvoltage detection enabled
  output logic      [13:0] fuse_limit_ma,       // Fuse current limit
  output logic      [8:0]  softstart_ma,        // FET soft-start current
  output logic      [15:0] storage_target_mv,   // Storage boost target
  output logic      [15:0] bus_target_mv,       // Supplement bus target
  output logic      [3:0]  hsilim_amps,         // Supplement high-side limit
  output logic      [6:0]  bus_uv_percent,      // Bus undervoltage percent
  output logic             bus_uv_reserved,     // Reserved code selected
  input  wire logic        storage_power_good,  // Storage power good
  input  wire logic        irq_source_n,        // Interrupt from other sources, active low
  output logic             interrupt_request_n, // Interrupt output, active low
  output logic             converter_enable,    // Converter may run
  input  wire logic [3:0]  check_discharge_time, // Discharge time code
  output logic      [3:0]  check_discharge_code, // Discharge time code passed on
  output logic      [3:0]  discharge_scale,     // Discharge time multiplier
  output logic             check_start,         // Health check start pulse
  input  wire logic [12:0] raw_events,          // Raw state-machine events
  output logic      [12:0] gated_events,        // Events allowed to transition
  input  wire logic        bias_above_lockout,  // Bias supply above lockout
  output logic      [4:0]  pin_pulldown_en,     // Pull-downs GPIO6,5,4,3,1
  output logic             bias_switcher_en,    // Bias switcher running
  output logic             linear_reg_en,       // Linear regulator running
  output logic             linear_reg_5v,       // Linear regulator at 5V
  input  wire logic        linear_reg_good,     // Linear regulator in range
  output logic             reset_output_n,      // Reset output, active low
  input  wire logic        blocking_fet_on,     // Manual FET enable
  input  wire logic        fet_fault,           // FET start failure pulse
  output logic             fet_gate_en,         // Blocking FET on
  output logic             boost_shutdown,      // Move to boost shutdown
  input  wire logic        bias_turning_off,    // Whole bias regulator off
  output logic             bias_discharge_en,   // Discharge bias rail
  output logic             measure_input_power, // Input power measurement
  input  wire logic        switch_fault,        // Supplement buck switch fault
  output logic             switch_fault_out     // Switch fault seen by logic
);

  // Register storage and decode
  logic [7:0] reg_ff [NUM_REGS];
  logic [7:0] rdata_ff;
  logic       rvalid_ff;
  logic       err_ff;
  logic [NUM_REGS-1:0] hit;
  logic [7:0] rd_mux;

  // Address compare for each register
  function automatic logic addr_hit(input logic [7:0] a, input int idx);
    return a == REG_ADDR[idx];
  endfunction

  // Reset value of one register, with factory trims
  function automatic logic [7:0] reset_val(input int idx);
    if (idx == IDX_OFS) begin
      return OFS_TRIM_VAL;
    end
    if (idx == IDX_GAIN) begin
      return REG_RESET[IDX_GAIN] | {2'b00, GAIN_TRIM_VAL};
    end
    return REG_RESET[idx];
  endfunction

  // Decoders and read mux
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      hit[i] = addr_hit(reg_addr, i);
      if (hit[i]) begin
        rd_mux = reg_ff[i];
      end
    end
  end

  wire any_hit = |hit;

  // Register writes, read-only bits keep their value
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    wire [7:0] nxt_reg = (reg_ff[g] & ~REG_WMASK[g]) | (reg_wdata & REG_WMASK[g]);
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        reg_ff[g] <= reset_val(g);
      end else if (reg_wr && hit[g]) begin
        reg_ff[g] <= nxt_reg;
      end
    end
  end

  // Read data and access status
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      rvalid_ff <= reg_rd;
      err_ff    <= (reg_rd || reg_wr) && !any_hit;
      if (reg_rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  assign reg_rdata  = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign reg_err    = err_ff;

  // Field extraction
  wire [7:0] r_uvf  = reg_ff[IDX_UV_FUSE];
  wire [7:0] r_gain = reg_ff[IDX_GAIN];
  wire [7:0] r_ov   = reg_ff[IDX_OV];
  wire [7:0] r_hchk = reg_ff[IDX_HCHK];
  wire [7:0] r_pd   = reg_ff[IDX_PD];
  wire [7:0] r_sm   = reg_ff[IDX_SM];
  wire [7:0] r_ba   = reg_ff[IDX_BIAS_A];
  wire [7:0] r_bb   = reg_ff[IDX_BIAS_B];
  wire [7:0] r_spla = reg_ff[IDX_SPL_A];
  wire [7:0] r_splb = reg_ff[IDX_SPL_B];

  logic [6:0] uv_pct;
  logic [6:0] ov_pct;

  // Code to value decode
  pmicpc_code_decode u_decode (
    .uv_code     (r_uvf[7:4]),
    .ov_code     (r_ov[7:4]),
    .fuse_code   (r_uvf[3:0]),
    .iss_code    (r_gain[7:6]),
    .boost_code  (reg_ff[IDX_BOOST]),
    .bus_code    (r_spla[6:0]),
    .hsilim_code (r_splb[7:5]),
    .bus_uv_code (r_splb[1:0]),
    .uv_pct      (uv_pct),
    .ov_pct      (ov_pct),
    .fuse_ma     (fuse_limit_ma),
    .iss_ma      (softstart_ma),
    .boost_mv    (storage_target_mv),
    .bus_mv      (bus_target_mv),
    .hsilim_a    (hsilim_amps),
    .bus_uv_pct  (bus_uv_percent),
    .bus_uv_rsvd (bus_uv_reserved)
  );

  // Thresholds scale the factory nominal by the chosen percent
  wire [18:0] uv_prod = {7'h00, factory_nominal_input_uv} * {12'h000, uv_pct};
  wire [18:0] ov_prod = {7'h00, factory_nominal_input_uv} * {12'h000, ov_pct};
  wire [18:0] uv_quot = uv_prod / 19'd100;
  wire [18:0] ov_quot = ov_prod / 19'd100;
  assign uv_threshold_mv = uv_quot[15:0];
  assign ov_threshold_mv = ov_quot[15:0];
  assign ov_detect_en    = (r_ov[7:4] != 4'h0);

  // Interrupt hold while storage is not good
  assign interrupt_request_n = irq_source_n && !(r_hchk[BIT_HOLD_IRQ] && !storage_power_good);

  // Converter run control
  assign converter_enable = !r_hchk[BIT_CONV_DIS];

  // Discharge time multiplier: 1, 2, 4 or both stacked to 8
  assign check_discharge_code = check_discharge_time;
  assign discharge_scale = 4'd1 << {r_hchk[BIT_TSET_4X], r_hchk[BIT_TSET_2X]};

  // Health check interval selection
  logic [39:0] hchk_cnt_ff;
  logic        check_start_ff;
  wire  [39:0] hchk_period = r_hchk[BIT_HCHK_4X] ? (HCHK_CYCLES << 2) :
                             r_hchk[BIT_HCHK_2X] ? (HCHK_CYCLES << 1) : HCHK_CYCLES;
  wire         hchk_done   = (hchk_cnt_ff >= hchk_period - 40'd1);
  wire  [39:0] nxt_hchk    = hchk_done ? 40'd0 : hchk_cnt_ff + 40'd1;

  // Health check timer, pulses once per interval
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hchk_cnt_ff    <= 40'd0;
      check_start_ff <= 1'b0;
    end else begin
      hchk_cnt_ff    <= nxt_hchk;
      check_start_ff <= hchk_done;
    end
  end

  assign check_start = check_start_ff;

  // Transition masks: bits 7..0 state masks, then pvin ov, compfail, bootcap
  wire [12:0] ev_mask = {r_pd[BIT_BOOTCAP_M], r_pd[BIT_COMPF_M], r_pd[BIT_PVIN_OV_M], 2'b00, r_sm};
  wire [12:0] ev_keep = {ev_mask[12:10], 2'b11, 8'hff};
  assign gated_events = raw_events & ~(ev_mask & ev_keep);

  // Unpowered pull-downs
  wire [4:0] pd_sel = {r_pd[7], r_pd[2], r_pd[1], r_bb[BIT_PD_GPIO3], r_pd[0]};
  assign pin_pulldown_en = bias_above_lockout ? 5'h00 : pd_sel;

  // Bias regulator controls
  assign bias_switcher_en  = !r_ba[BIT_FORCE_OFF];
  assign linear_reg_en     = 1'b1;
  assign linear_reg_5v     = r_ba[BIT_LDO_5V];
  assign bias_discharge_en = bias_turning_off && !r_bb[BIT_DIS_DISCHG];
  assign measure_input_power = r_pd[BIT_MEAS_PWR];

  // Reset output follows regulator health when enabled
  assign reset_output_n = !(r_ba[BIT_LINEAR_REG_RESET_DRIVE] && !linear_reg_good);

  // Supplement buck switch fault masking
  assign switch_fault_out = switch_fault && !r_spla[BIT_SW_MASK];

  // Blocking FET request: automatic unless manual select
  wire fet_request = r_ba[BIT_FET_MANUAL] ? blocking_fet_on : 1'b1;
  wire retry_once  = r_ba[BIT_FET_RETRY];

  pmicpc_fet_e fet_st_ff;
  pmicpc_fet_e nxt_fet_st;
  logic [23:0] hic_cnt_ff;
  logic [23:0] nxt_hic_cnt;
  logic        retried_ff;
  logic        nxt_retried;

  // FET retry sequencing
  always_comb begin
    nxt_fet_st  = fet_st_ff;
    nxt_hic_cnt = hic_cnt_ff;
    nxt_retried = retried_ff;
    unique case (fet_st_ff)
      BF_OFF: begin
        nxt_retried = 1'b0;
        if (fet_request) begin
          nxt_fet_st = BF_ON;
        end
      end
      BF_ON: begin
        if (!fet_request) begin
          nxt_fet_st = BF_OFF;
        end else if (fet_fault) begin
          if (retry_once && retried_ff) begin
            nxt_fet_st = BF_SHUTDOWN;
          end else begin
            nxt_fet_st  = BF_HICCUP;
            nxt_hic_cnt = 24'd0;
          end
        end
      end
      BF_HICCUP: begin
        nxt_hic_cnt = hic_cnt_ff + 24'd1;
        if (!fet_request) begin
          nxt_fet_st = BF_OFF;
        end else if (hic_cnt_ff >= HICCUP_CYCLES - 24'd1) begin
          nxt_fet_st  = BF_ON;
          nxt_retried = 1'b1;
        end
      end
      BF_SHUTDOWN: begin
        if (!fet_request) begin
          nxt_fet_st = BF_OFF;
        end
      end
    endcase
  end

  // FET state registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fet_st_ff  <= BF_OFF;
      hic_cnt_ff <= 24'd0;
      retried_ff <= 1'b0;
    end else begin
      fet_st_ff  <= nxt_fet_st;
      hic_cnt_ff <= nxt_hic_cnt;
      retried_ff <= nxt_retried;
    end
  end

  assign fet_gate_en    = (fet_st_ff == BF_ON);
  assign boost_shutdown = (fet_st_ff == BF_SHUTDOWN);

  // The offset trim byte is not writable; the gain trim bits share a fully writable register

endmodule

// [include/pmicpc_pkg.sv]
// Package with register map, field positions, reset values and timing constants
package pmicpc_pkg;

  // Register indices in the bank
  localparam int NUM_REGS = 13;
  localparam logic [7:0] ADDR_UV_FUSE   = 8'h2d;
  localparam logic [7:0] ADDR_OFS_TRIM  = 8'h2e;
  localparam logic [7:0] ADDR_GAIN_ISS  = 8'h2f;
  localparam logic [7:0] ADDR_OV_CTRL   = 8'h30;
  localparam logic [7:0] ADDR_HCHK_CTRL = 8'h31;
  localparam logic [7:0] ADDR_PD_MASKS  = 8'h32;
  localparam logic [7:0] ADDR_SM_MASKS  = 8'h33;
  localparam logic [7:0] ADDR_BIAS_A    = 8'h34;
  localparam logic [7:0] ADDR_BIAS_B    = 8'h35;
  localparam logic [7:0] ADDR_BUCK1_ST  = 8'h40;
  localparam logic [7:0] ADDR_BOOST_V   = 8'hca;
  localparam logic [7:0] ADDR_SPL_A     = 8'hcb;
  localparam logic [7:0] ADDR_SPL_B     = 8'hcc;

  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33,
                                                 8'h34, 8'h35, 8'h40, 8'hca, 8'hcb, 8'hcc};
  // Bits that software may change; others hold their reset value
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
                                                  8'h1f, 8'h8f, 8'hff, 8'hff, 8'hff, 8'hff};
  // Power-up values (trim registers get their factory value separately)
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h02, 8'h00, 8'h40, 8'h4f, 8'h20, 8'ha3, 8'h02,
                                                  8'h01, 8'h80, 8'h00, 8'he1, 8'h92, 8'h6d};
  localparam int IDX_UV_FUSE = 0;
  localparam int IDX_OFS     = 1;
  localparam int IDX_GAIN    = 2;
  localparam int IDX_OV      = 3;
  localparam int IDX_HCHK    = 4;
  localparam int IDX_PD      = 5;
  localparam int IDX_SM      = 6;
  localparam int IDX_BIAS_A  = 7;
  localparam int IDX_BIAS_B  = 8;
  localparam int IDX_BOOST   = 10;
  localparam int IDX_SPL_A   = 11;
  localparam int IDX_SPL_B   = 12;

  // Single-bit field positions
  localparam int BIT_HOLD_IRQ   = 7;
  localparam int BIT_CONV_DIS   = 6;
  localparam int BIT_TSET_2X    = 3;
  localparam int BIT_TSET_4X    = 2;
  localparam int BIT_HCHK_2X    = 1;
  localparam int BIT_HCHK_4X    = 0;
  localparam int BIT_PVIN_OV_M  = 6;
  localparam int BIT_MEAS_PWR   = 5;
  localparam int BIT_COMPF_M    = 4;
  localparam int BIT_BOOTCAP_M  = 3;
  localparam int BIT_FORCE_OFF  = 4;
  localparam int BIT_LDO_5V     = 3;
  localparam int BIT_LINEAR_REG_RESET_DRIVE    = 2;
  localparam int BIT_FET_MANUAL = 1;
  localparam int BIT_FET_RETRY  = 0;
  localparam int BIT_DIS_DISCHG = 7;
  localparam int BIT_PD_GPIO3   = 2;
  localparam int BIT_SW_MASK    = 7;

  // Timing: clock period, health check base interval and hiccup wait
  localparam longint CLK_PERIOD_NS     = 10;
  localparam longint HCHK_BASE_MIN     = 4;
  localparam longint HCHK_BASE_CYCLES  = (HCHK_BASE_MIN * 64'd60_000_000_000) / CLK_PERIOD_NS;
  localparam longint FET_HICCUP_US     = 1000;
  localparam longint FET_HICCUP_CYCLES = (FET_HICCUP_US * 64'd1000) / CLK_PERIOD_NS;

  // Blocking FET retry states
  typedef enum logic [1:0] {
    BF_OFF      = 2'b00,
    BF_ON       = 2'b01,
    BF_HICCUP   = 2'b10,
    BF_SHUTDOWN = 2'b11
  } pmicpc_fet_e;

endpackage

// [verif/pmicpc_host_model.sv]
// Host model that drives the register port
`timescale 1ns/1ps
module pmicpc_host_model (
  input  wire logic       mclk,       // Clock
  output logic            reg_wr,     // Write strobe
  output logic            reg_rd,     // Read strobe
  output logic      [7:0] reg_addr,   // Address
  output logic      [7:0] reg_wdata,  // Write data
  input  wire logic [7:0] reg_rdata,  // Read data
  input  wire logic       reg_rvalid, // Read valid
  input  wire logic       reg_err     // Unmapped access
);
  // Idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask

  // One-cycle read returning error, valid and data
  task automatic rd(input logic [7:0] a, output logic [9:0] r);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    r = {reg_err, reg_rvalid, reg_rdata};
  endtask
endmodule

// [verif/pmicpc_regs_assertions.sv]
// Checker of port relations of the protection register bank
`timescale 1ns/1ps
module pmicpc_regs_chk (
  input wire logic        mclk,                // Clock
  input wire logic        rst_b,               // Reset, low
  input wire logic        reg_wr,              // Write strobe
  input wire logic        reg_rd,              // Read strobe
  input wire logic [7:0]  reg_addr,            // Address
  input wire logic [7:0]  reg_wdata,           // Write data
  input wire logic        reg_rvalid,          // Read valid
  input wire logic        reg_err,             // Unmapped access
  input wire logic        ov_detect_en,        // Overvoltage on
  input wire logic        storage_power_good,  // Storage good
  input wire logic        interrupt_request_n, // Interrupt, low
  input wire logic        converter_enable,    // Converter runs
  input wire logic        check_start,         // Check pulse
  input wire logic [12:0] raw_events,          // Raw events
  input wire logic [12:0] gated_events,        // Gated events
  input wire logic        bias_above_lockout,  // Bias good
  input wire logic [4:0]  pin_pulldown_en,     // Pull-downs
  input wire logic        bias_switcher_en,    // Switcher runs
  input wire logic        linear_reg_en,       // Linear regulator runs
  input wire logic        linear_reg_good,     // Linear regulator good
  input wire logic        reset_output_n,      // Reset out, low
  input wire logic        boost_shutdown,      // Boost shutdown
  input wire logic        switch_fault,        // Switch fault in
  input wire logic        switch_fault_out     // Switch fault out
);
  logic hold_ff; // Copy of the interrupt hold bit

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Follow the hold bit from host writes
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) hold_ff <= 1'b0;
    else if (reg_wr && reg_addr == 8'h31) hold_ff <= reg_wdata[7];
  end

  a_read_answer: assert property (reg_rd |=> reg_rvalid || reg_err)
    else $error("read not answered");
  a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without read");
  a_conv_disable: assert property (reg_wr && reg_addr == 8'h31 |=> converter_enable == !$past(reg_wdata[6]))
    else $error("converter enable wrong");
  a_ov_enable: assert property (reg_wr && reg_addr == 8'h30 |=> ov_detect_en == ($past(reg_wdata[7:4]) != 4'h0))
    else $error("overvoltage enable wrong");
  a_irq_hold: assert property (hold_ff && !storage_power_good |-> !interrupt_request_n)
    else $error("interrupt not held");
  a_pulldown_off: assert property (bias_above_lockout |-> pin_pulldown_en == 5'h00)
    else $error("pull-down with bias up");
  a_reset_good: assert property (linear_reg_good |-> reset_output_n)
    else $error("reset with regulator good");
  a_event_mask: assert property ((gated_events & ~raw_events) == 13'h0 && gated_events[9:8] == raw_events[9:8])
    else $error("event gating wrong");
  a_force_off: assert property (reg_wr && reg_addr == 8'h34 && reg_wdata[4] |=> !bias_switcher_en && linear_reg_en)
    else $error("force-off wrong");
  a_fault_idle: assert property (!switch_fault |-> !switch_fault_out)
    else $error("switch fault invented");
  a_start_pulse: assert property (check_start |=> !check_start [*8])
    else $error("check pulses too close");

  // Main scenarios reached
  c_read: cover property (reg_rvalid);
  c_unmapped: cover property (reg_err);
  c_check: cover property (check_start);
  c_shutdown: cover property (boost_shutdown);
endmodule

// [verif/pmicpc_regs_test.sv]
// Self-checking bench of the protection register bank
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module pmicpc_regs_test
  import pmicpc_pkg::*;
;
  logic        mclk, rst_b, reg_wr, reg_rd, reg_rvalid, reg_err, ov_detect_en, bus_uv_reserved;
  logic        storage_power_good, irq_source_n, interrupt_request_n, converter_enable, check_start;
  logic        bias_above_lockout, bias_switcher_en, linear_reg_en, linear_reg_5v, linear_reg_good;
  logic        reset_output_n, blocking_fet_on, fet_fault, fet_gate_en, boost_shutdown, bias_turning_off;
  logic        bias_discharge_en, measure_input_power, switch_fault, switch_fault_out;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] factory_nominal_input_uv;
  logic [15:0] uv_threshold_mv, ov_threshold_mv, storage_target_mv, bus_target_mv;
  logic [13:0] fuse_limit_ma;
  logic [8:0]  softstart_ma;
  logic [3:0]  hsilim_amps, check_discharge_time, check_discharge_code, discharge_scale;
  logic [6:0]  bus_uv_percent;
  logic [12:0] raw_events, gated_events;
  logic [4:0]  pin_pulldown_en;
  logic [9:0]  r;
  int          i, n_tests, err_count;
  int          iss [4] = '{147, 212, 305, 483};
  int          scl [4] = '{1, 4, 2, 8};

  pmicpc_regs #(.HCHK_CYCLES(40'd20), .HICCUP_CYCLES(24'd5)) dut (.*);
  pmicpc_host_model host (.*);

  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    $display("[FAIL] watchdog exp done got hang");
    finish_test;
  end

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  // One-cycle start failure of the blocking switch
  task automatic fault;
    @(posedge mclk);
    fet_fault <= 1'b1;
    @(posedge mclk);
    fet_fault <= 1'b0;
    #1;
  endtask

  // Cycles between two health check pulses
  task automatic period(input logic [7:0] v, input int exp);
    int n;
    host.wr(8'h31, v);
    n = 0;
    while (check_start !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    tick;
    n = 1;
    while (check_start !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    `CHK("period", exp, n)
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    storage_power_good = 1'b0;
    irq_source_n = 1'b1;
    check_discharge_time = 4'h5;
    raw_events = 13'h1fff;
    bias_above_lockout = 1'b0;
    linear_reg_good = 1'b0;
    blocking_fet_on = 1'b0;
    fet_fault = 1'b0;
    bias_turning_off = 1'b1;
    switch_fault = 1'b1;
    factory_nominal_input_uv = 12'd1000;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    tick;
    for (i = 0; i < NUM_REGS; i++) begin
      host.rd(REG_ADDR[i], r);
      `CHK("reset", {2'b01, (i == IDX_OFS ? 8'h80 : i == IDX_GAIN ? 8'h60 : REG_RESET[i])}, r)
    end
    `CHK("pulldown", 6'h35, {measure_input_power, pin_pulldown_en})
    `CHK("events", 13'h1ffd, gated_events)
    `CHK("irq", 1'b1, interrupt_request_n)
    `CHK("rst_out", 1'b1, reset_output_n)
    `CHK("dischg", 1'b0, bias_discharge_en)
    `CHK("sw_mask", 1'b0, switch_fault_out)
    `CHK("fet_auto", 1'b1, fet_gate_en)
    // Retry once, then shutdown; manual mode clears it
    fault;
    `CHK("fet_off", 1'b0, fet_gate_en)
    repeat (8) tick;
    `CHK("fet_retry", 1'b1, fet_gate_en)
    fault;
    `CHK("shutdown", 1'b1, boost_shutdown)
    host.wr(8'h34, 8'h02);
    repeat (2) tick;
    `CHK("shut_clr", 1'b0, boost_shutdown)
    `CHK("fet_man", 1'b0, fet_gate_en)
    @(posedge mclk) blocking_fet_on <= 1'b1;
    repeat (2) tick;
    `CHK("fet_man_on", 1'b1, fet_gate_en)
    host.wr(8'h34, 8'h00);
    @(posedge mclk) blocking_fet_on <= 1'b0;
    repeat (2) tick;
    `CHK("fet_auto2", 1'b1, fet_gate_en)
    fault;
    repeat (8) tick;
    fault;
    repeat (8) tick;
    `CHK("retry_perm", 2'b01, {boost_shutdown, fet_gate_en})
    // Interrupt hold, discharge, bias controls, pull-downs, masks
    host.wr(8'h31, 8'ha0);
    `CHK("irq_hold", 1'b0, interrupt_request_n)
    @(posedge mclk) storage_power_good <= 1'b1;
    #1;
    `CHK("irq_rel", 1'b1, interrupt_request_n)
    host.wr(8'h35, 8'h00);
    `CHK("dischg_on", 1'b1, bias_discharge_en)
    host.wr(8'h34, 8'h15);
    `CHK("force_off", 2'b01, {bias_switcher_en, linear_reg_en})
    `CHK("rst_drive", 1'b0, reset_output_n)
    @(posedge mclk) linear_reg_good <= 1'b1;
    @(posedge mclk) bias_above_lockout <= 1'b1;
    #1;
    `CHK("rst_good", 1'b1, reset_output_n)
    `CHK("pd_off", 5'h00, pin_pulldown_en)
    host.wr(8'h33, 8'hff);
    host.wr(8'h32, 8'h58);
    `CHK("ev_mask", 13'h0300, gated_events)
    // Unmapped and read-only places; trim written only to see it refused
    host.rd(8'h36, r);
    `CHK("unmapped", 9'h100, {r[9], r[7:0]})
    host.wr(8'h36, 8'h5a);
    `CHK("wr_err", 1'b1, reg_err)
    host.wr(8'h2e, 8'h55);
    host.rd(8'h2e, r);
    `CHK("trim_ro", 10'h180, r)
    host.wr(8'h34, 8'hff);
    host.rd(8'h34, r);
    `CHK("bias_ro", 11'h51f, {linear_reg_5v, r})
    // Code tables of every field, only the end codes for boost and bus
    for (i = 0; i < 16; i++) begin
      host.wr(8'h2d, {i[3:0], i[3:0]});
      `CHK("uv_thr", 10 * (80 + i), uv_threshold_mv)
      `CHK("fuse", (i == 0 ? 1500 : (i > 11 ? 12 : i + 1) * 1000), fuse_limit_ma)
      host.wr(8'h30, {i[3:0], 4'hf});
      `CHK("ov_thr", (i == 0 ? 0 : 10 * (105 + i)), ov_threshold_mv)
      `CHK("ov_en", (i != 0), ov_detect_en)
      if (i < 8) begin
        host.wr(8'hcc, {i[2:0], 5'h0d});
        `CHK("hsilim", i + 3, hsilim_amps)
      end
      if (i < 4) begin
        host.wr(8'h2f, {i[1:0], 6'h20});
        `CHK("iss", iss[i], softstart_ma)
        host.wr(8'hcc, {6'h1b, i[1:0]});
        `CHK("bus_uv", {(i[0] ? 7'd70 : 7'd60), i[1]}, {bus_uv_percent, bus_uv_reserved})
        host.wr(8'h31, {1'b0, i[0], 2'b10, i[1:0], 2'b00});
        `CHK("scale", scl[i], discharge_scale)
        `CHK("conv_en", !i[0], converter_enable)
        `CHK("tset", 4'h5, check_discharge_code)
      end
    end
    host.wr(8'hca, 8'h00);
    `CHK("boost_lo", 5500, storage_target_mv)
    host.wr(8'hca, 8'hff);
    `CHK("boost_hi", 31000, storage_target_mv)
    host.wr(8'hcb, 8'h80);
    `CHK("bus_lo", 2500, bus_target_mv)
    host.wr(8'hcb, 8'h7f);
    `CHK("bus_hi", 15200, bus_target_mv)
    `CHK("sw_pass", 1'b1, switch_fault_out)
    period(8'h00, 20);
    period(8'h02, 40);
    period(8'h01, 80);
    finish_test;
  end
endmodule

bind pmicpc_regs pmicpc_regs_chk u_chk (.*);
